// >>> evpa_pkg.sv
// Constants shared by the exception arbiter and its vector address unit
package evpa_pkg;
    // ********************************************************
    // Sizes
    // ********************************************************
    localparam int NUM_LINES = 30;
    localparam int NUM_EXC   = 46;
    localparam int EXC_W     = 6;
    localparam int PRIO_W    = 3;
    localparam int GRP_W     = 4;
    localparam int KEY_W     = GRP_W + PRIO_W;
    localparam int SPLIT_W   = 2;
    localparam int NUM_PRIO_WORDS = 12;
    // ********************************************************
    // Exception numbers
    // ********************************************************
    localparam logic [EXC_W-1:0] EXC_RESET = 6'h01;
    localparam logic [EXC_W-1:0] EXC_NMI   = 6'h02;
    localparam logic [EXC_W-1:0] EXC_HARD  = 6'h03;
    localparam logic [EXC_W-1:0] EXC_LINE0 = 6'h10;
    // Programmable: 4,5,6,11,12,14,15 and lines 16..45
    localparam logic [NUM_EXC-1:0] PROG_MASK =
        46'h3FFF_FFFF_D870;
    // Sources that hardware may raise (no reset, no reserved)
    localparam logic [NUM_EXC-1:0] REQ_MASK  =
        46'h3FFF_FFFF_D87C;
    // ********************************************************
    // Priority keys: fixed levels -3,-2,-1 map below all others
    // ********************************************************
    localparam logic [GRP_W-1:0] GRP_RESET   = 4'h0;
    localparam logic [GRP_W-1:0] GRP_NMI     = 4'h1;
    localparam logic [GRP_W-1:0] GRP_HARD    = 4'h2;
    localparam logic [GRP_W-1:0] GRP_PROG    = 4'h3;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
    localparam logic [SPLIT_W-1:0] SPLIT_RESET = 2'h0;
    // ********************************************************
    // Table relocation
    // ********************************************************
    localparam logic [31:0] TBR_RESET = 32'h0000_0000;
    localparam logic [31:0] TBR_MIN   = 32'h0000_0100;
    localparam logic [31:0] TBR_MAX   = 32'h3FFF_FF00;
    localparam logic [31:0] TBR_ALIGN = 32'hFFFF_FF00;
    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [7:0] OFF_TBR    = 8'h00;
    localparam logic [7:0] OFF_SPLIT  = 8'h04;
    localparam logic [7:0] OFF_SWPEND = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_PEND_L = 8'h10;
    localparam logic [7:0] OFF_PEND_H = 8'h14;
    localparam logic [7:0] OFF_ACT_L  = 8'h18;
    localparam logic [7:0] OFF_ACT_H  = 8'h1C;
    localparam logic [7:0] OFF_PRIO   = 8'h40;
    localparam logic [7:0] OFF_PRIO_END = 8'h6C;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam int HPROT_PRIV = 1;
endpackage : evpa_pkg

// >>> evpa_vec_addr.sv
// Vector table address unit: handler and stack pointer word addresses
`timescale 1ns/1ps
module evpa_vec_addr (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rstn_i,
    // Table base and selected exception
    input  wire logic [31:0]                 base_i,
    input  wire logic [evpa_pkg::EXC_W-1:0]  num_i,
    // Addresses
    output logic      [31:0]                 vec_addr_o,
    output logic      [31:0]                 sp_addr_o
);
    import evpa_pkg::*;

    logic [31:0] vec_d;

    always_comb begin
        vec_d = base_i + {24'h00_0000, num_i, 2'b00};
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            vec_addr_o <= TBR_RESET;
            sp_addr_o  <= TBR_RESET;
        end else begin
            vec_addr_o <= vec_d;
            sp_addr_o  <= base_i;
        end
    end
endmodule : evpa_vec_addr

// >>> evpa_top.sv
// Exception arbiter with priority grouping and relocatable vector table
`timescale 1ns/1ps
module evpa_top (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rstn_i,
    // AHB-Lite slave
    input  wire logic                          hsel_i,
    input  wire logic [31:0]                   haddr_i,
    input  wire logic [1:0]                    htrans_i,
    input  wire logic                          hwrite_i,
    input  wire logic [2:0]                    hsize_i,
    input  wire logic [3:0]                    hprot_i,
    input  wire logic [31:0]                   hwdata_i,
    input  wire logic                          hready_i,
    output logic                               hreadyout_o,
    output logic                               hresp_o,
    output logic      [31:0]                   hrdata_o,
    // Exception sources
    input  wire logic [evpa_pkg::NUM_LINES-1:0] irq_i,
    input  wire logic [15:0]                   sys_req_i,
    // Core side
    output logic                               take_req_o,
    output logic      [evpa_pkg::EXC_W-1:0]    take_num_o,
    output logic      [31:0]                   vec_addr_o,
    output logic      [31:0]                   sp_addr_o,
    input  wire logic                          core_ack_i,
    input  wire logic                          core_ret_i
);
    import evpa_pkg::*;

    // ********************************************************
    // Priority key of one exception
    // ********************************************************
    function automatic logic [KEY_W-1:0] prio_key(
        input logic [EXC_W-1:0]   num,
        input logic [PRIO_W-1:0]  p,
        input logic [SPLIT_W-1:0] split
    );
        logic [PRIO_W-1:0] smask;
        logic [GRP_W-1:0]  grp;
        smask = PRIO_W'((4'h1 << split) - 4'h1);
        grp   = GRP_PROG + GRP_W'(p >> split);
        case (num)
            EXC_RESET: prio_key = {GRP_RESET, PRIO_RESET};
            EXC_NMI:   prio_key = {GRP_NMI, PRIO_RESET};
            EXC_HARD:  prio_key = {GRP_HARD, PRIO_RESET};
            default:   prio_key = {grp, p & smask};
        endcase
    endfunction : prio_key

    // ********************************************************
    // Write strobe for one register offset
    // ********************************************************
    function automatic logic wr_hit(
        input logic       en,
        input logic [7:0] at,
        input logic [7:0] off
    );
        wr_hit = en && at == off;
    endfunction : wr_hit

    // ********************************************************
    // State
    // ********************************************************
    logic [31:0]        base_q;
    logic [SPLIT_W-1:0] split_q;
    logic [PRIO_W-1:0]  prio_q [NUM_EXC];
    logic [NUM_EXC-1:0] pend_q;
    logic [NUM_EXC-1:0] pend_d;
    logic [NUM_EXC-1:0] act_q;
    logic [NUM_EXC-1:0] act_d;
    logic               take_q;
    logic [EXC_W-1:0]   take_num_q;

    // Bus address phase capture
    logic               wr_q;
    logic               priv_q;
    logic [7:0]         addr_q;
    logic [31:0]        rdata_q;
    logic               aph;
    logic [31:0]        rdata_d;

    // Arbitration results
    logic               win_valid;
    logic [EXC_W-1:0]   win_num;
    logic [KEY_W-1:0]   win_key;
    logic               run_valid;
    logic [EXC_W-1:0]   run_num;
    logic [KEY_W-1:0]   run_key;
    logic               take;
    logic [NUM_EXC-1:0] req_set;
    logic [NUM_EXC-1:0] sw_set;
    logic               wr_en;
    logic               base_ok;
    logic [31:0]        status_w;

    // ********************************************************
    // AHB-Lite slave
    // ********************************************************
    assign aph         = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = rdata_q;
    assign wr_en       = wr_q;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wr_q   <= 1'b0;
            priv_q <= 1'b0;
        end else begin
            wr_q   <= aph && hwrite_i;
            priv_q <= hprot_i[HPROT_PRIV];
        end
    end

    // Address of the data phase that follows
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            addr_q <= OFF_TBR;
        end else if (aph) begin
            addr_q <= haddr_i[7:0];
        end
    end

    always_comb begin
        logic [7:0] idx;
        idx     = 8'h00;
        rdata_d = 32'h0000_0000;
        case (haddr_i[7:0])
            OFF_TBR:    rdata_d = base_q;
            OFF_SPLIT:  rdata_d = {30'h0000_0000, split_q};
            OFF_STATUS: rdata_d = status_w;
            OFF_PEND_L: rdata_d = pend_q[31:0];
            OFF_PEND_H: rdata_d = {18'h0_0000, pend_q[NUM_EXC-1:32]};
            OFF_ACT_L:  rdata_d = act_q[31:0];
            OFF_ACT_H:  rdata_d = {18'h0_0000, act_q[NUM_EXC-1:32]};
            default: begin
                if (haddr_i[7:0] >= OFF_PRIO &&
                    haddr_i[7:0] <= OFF_PRIO_END) begin
                    idx = haddr_i[7:0] - OFF_PRIO;
                    for (int k = 0; k < 4; k++) begin
                        if (int'(idx) + k < NUM_EXC) begin
                            rdata_d[8*k +: PRIO_W] =
                                prio_q[int'(idx) + k];
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (aph && !hwrite_i) begin
            rdata_q <= rdata_d;
        end
    end

    // ********************************************************
    // Status word
    // ********************************************************
    always_comb begin
        status_w = {16'h0000, take_q, win_valid, win_num, 1'b0,
                    run_valid, run_num};
    end

    // ********************************************************
    // Table base and grouping split
    // ********************************************************
    // Out of range or unprivileged bases are dropped silently
    assign base_ok = priv_q && hwdata_i >= TBR_MIN &&
                     hwdata_i <= TBR_MAX;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            base_q <= TBR_RESET;
        end else if (wr_hit(wr_en, addr_q, OFF_TBR) && base_ok) begin
            base_q <= hwdata_i & TBR_ALIGN;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            split_q <= SPLIT_RESET;
        end else if (wr_hit(wr_en, addr_q, OFF_SPLIT)) begin
            split_q <= hwdata_i[SPLIT_W-1:0];
        end
    end

    // ********************************************************
    // Priority fields, four exceptions per word
    // ********************************************************
    genvar e;
    generate
        for (e = 0; e < NUM_EXC; e++) begin : g_prio
            localparam logic [7:0] WOFF = OFF_PRIO + 8'(e & ~3);
            localparam int         LANE = e % 4;
            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    prio_q[e] <= PRIO_RESET;
                end else if (PROG_MASK[e] &&
                             wr_hit(wr_en, addr_q, WOFF)) begin
                    prio_q[e] <= hwdata_i[8*LANE +: PRIO_W];
                end
            end
        end
    endgenerate

    // ********************************************************
    // Arbitration
    // ********************************************************
    always_comb begin
        logic [KEY_W-1:0] k;
        k         = '0;
        win_valid = 1'b0;
        win_num   = '0;
        win_key   = '1;
        run_valid = 1'b0;
        run_num   = '0;
        run_key   = '1;
        for (int i = 0; i < NUM_EXC; i++) begin
            k = prio_key(EXC_W'(i), prio_q[i], split_q);
            // Ascending scan, strict compare: lowest number wins ties
            if (pend_q[i] &&
                (!win_valid || k < win_key)) begin
                win_valid = 1'b1;
                win_num   = EXC_W'(i);
                win_key   = k;
            end
            if (act_q[i] && (!run_valid || k < run_key)) begin
                run_valid = 1'b1;
                run_num   = EXC_W'(i);
                run_key   = k;
            end
        end
        // Only a strictly smaller group preempts
        take = win_valid &&
               (!run_valid ||
                win_key[KEY_W-1 -: GRP_W] <
                run_key[KEY_W-1 -: GRP_W]);
    end

    // ********************************************************
    // Pending and active tracking
    // ********************************************************
    always_comb begin
        req_set = {irq_i, sys_req_i} & REQ_MASK;
        sw_set  = '0;
        if (wr_hit(wr_en, addr_q, OFF_SWPEND) &&
            hwdata_i[EXC_W-1:0] < EXC_W'(NUM_EXC)) begin
            sw_set[hwdata_i[EXC_W-1:0]] = 1'b1;
        end
        // Reserved numbers and reset cannot be pended by software
        sw_set = sw_set & REQ_MASK;
    end

    always_comb begin
        pend_d = pend_q;
        act_d  = act_q;
        if (core_ret_i && run_valid) begin
            act_d[run_num] = 1'b0;
        end
        if (core_ack_i && take_q) begin
            pend_d[take_num_q] = 1'b0;
            // Reset runs in thread mode, so it never blocks others
            if (take_num_q != EXC_RESET) begin
                act_d[take_num_q] = 1'b1;
            end
        end
        // A new request beats the clear in the same cycle
        pend_d = pend_d | req_set | sw_set;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pend_q            <= '0;
            pend_q[EXC_RESET] <= 1'b1;
        end else begin
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            act_q <= '0;
        end else begin
            act_q <= act_d;
        end
    end

    // ********************************************************
    // Core request
    // ********************************************************
    // An acknowledged offer drops for one cycle before the next
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            take_q <= 1'b0;
        end else begin
            take_q <= take && !core_ack_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            take_num_q <= '0;
        end else begin
            take_num_q <= win_num;
        end
    end

    assign take_req_o = take_q;
    assign take_num_o = take_num_q;

    evpa_vec_addr u_vec (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .base_i     (base_q),
        .num_i      (win_num),
        .vec_addr_o (vec_addr_o),
        .sp_addr_o  (sp_addr_o)
    );
endmodule : evpa_top

// >>> evpa_top_chk.sv
// Port checker of the exception arbiter, bound to its top module
`timescale 1ns/1ps
module evpa_chk (
    // Clock and reset
    input wire logic                       clk_i,
    input wire logic                       rstn_i,
    // Bus and sources
    input wire logic                       hsel_i,
    input wire logic                       hready_i,
    input wire logic [1:0]                 htrans_i,
    input wire logic                       hwrite_i,
    input wire logic [3:0]                 hprot_i,
    input wire logic [15:0]                sys_req_i,
    // Core side
    input wire logic                       core_ack_i,
    input wire logic                       take_req_o,
    input wire logic [evpa_pkg::EXC_W-1:0] take_num_o,
    input wire logic [31:0]                vec_addr_o,
    input wire logic [31:0]                sp_addr_o
);
    import evpa_pkg::*;
    logic pw;
    assign pw = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ
        && hwrite_i && hprot_i[HPROT_PRIV];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_vec_offset: assert property (
        take_req_o |-> vec_addr_o ==
            sp_addr_o + {24'h00_0000, take_num_o, 2'b00})
        else $error("vector address is not base plus four times number");
    a_vec_valid: assert property (
        take_req_o |-> take_num_o < NUM_EXC && take_num_o != 6'h00
        && (PROG_MASK[take_num_o] || take_num_o <= EXC_HARD))
        else $error("offered exception number is not a real source");
    a_reset_base: assert property (disable iff (1'b0)
        !rstn_i |=> sp_addr_o == TBR_RESET && !take_req_o)
        else $error("table base or offer not cleared by reset");
    a_reset_take: assert property (
        $rose(rstn_i) |-> ##[1:2] (take_req_o && take_num_o == EXC_RESET
        && vec_addr_o == 32'h0000_0004))
        else $error("reset exception not offered after reset");
    a_base_align: assert property (sp_addr_o[7:0] == 8'h00)
        else $error("table base not on a 256 byte boundary");
    a_base_range: assert property (
        sp_addr_o == TBR_RESET ||
        (sp_addr_o >= TBR_MIN && sp_addr_o <= TBR_MAX))
        else $error("table base outside the allowed range");
    a_base_priv: assert property (
        $changed(sp_addr_o) |-> $past(pw, 2) || $past(pw, 3))
        else $error("table base moved without a privileged write");
    a_ack_falls: assert property (
        take_req_o && core_ack_i |=> !take_req_o)
        else $error("offer stays up after the core took it");
    a_fixed_first: assert property (
        $past(sys_req_i[3], 2) && $past(sys_req_i[3]) && take_req_o
        |-> take_num_o <= EXC_HARD)
        else $error("programmable exception beat a pending hard fault");
    c_line_take: cover property (take_req_o && take_num_o >= EXC_LINE0);
    c_ack: cover property (take_req_o && core_ack_i);
    c_reloc: cover property (sp_addr_o != TBR_RESET);
endmodule : evpa_chk
bind evpa_top evpa_chk chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .hsel_i(hsel_i), .hready_i(hready_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hprot_i(hprot_i), .sys_req_i(sys_req_i),
    .core_ack_i(core_ack_i), .take_req_o(take_req_o),
    .take_num_o(take_num_o), .vec_addr_o(vec_addr_o),
    .sp_addr_o(sp_addr_o));

// >>> evpa_core_model.sv
// Core model: takes the offered exception after a chosen delay
`timescale 1ns/1ps
module evpa_core_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Offer and control
    input  wire logic       take_req_i,
    input  wire logic       en_i,
    input  wire logic [1:0] lat_i,
    output logic            ack_o
);
    logic [1:0] wait_q;
    logic [1:0] hold_q;
    // Hold-off keeps one take from being acknowledged twice
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ack_o <= 1'b0;
            wait_q <= 2'h0;
            hold_q <= 2'h0;
        end else if (hold_q != 2'h0) begin
            ack_o <= 1'b0;
            hold_q <= hold_q - 2'h1;
        end else if (take_req_i && en_i) begin
            if (wait_q == lat_i) begin
                ack_o <= 1'b1;
                hold_q <= 2'h2;
                wait_q <= 2'h0;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end else begin
            wait_q <= 2'h0;
        end
    end
endmodule : evpa_core_model

// >>> exception_vector_priority_arbiter_bench.sv
// Self-checking bench of the exception arbiter
`timescale 1ns/1ps
module exception_vector_priority_arbiter_bench;
    import evpa_pkg::*;
    logic        clk_i  = 1'b0;
    logic        rstn_i = 1'b0;
    logic [31:0] haddr  = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [3:0]  hprot  = 4'h0;
    logic [31:0] hwdata = 32'h0;
    logic [29:0] irq    = 30'h0;
    logic [15:0] sysr   = 16'h0;
    logic        ret    = 1'b0;
    logic        en     = 1'b1;
    logic [1:0]  lat    = 2'h0;
    logic [7:0]  rnd    = 8'h21;
    logic        hready, hresp, take, ack;
    logic [5:0]  num;
    logic [31:0] hrdata, vec, sp, r;
    logic [2:0]  pr [48] = '{default: 3'h0};
    logic [31:0] bd [6] = '{32'h0000_0200, 32'h0000_0000, 32'h4000_0000,
        32'h3FFF_FF00, 32'h0000_0100, 32'h4000_0100};
    logic [31:0] be [6] = '{32'h0, 32'h0, 32'h0, 32'h3FFF_FF00,
        32'h0000_0100, 32'h0000_0100};
    int          errors = 0;
    int          comparisons = 0;
    int          a, b;
    logic [31:0] tbl [64];
    evpa_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hprot_i(hprot), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata), .irq_i(irq), .sys_req_i(sysr),
        .take_req_o(take), .take_num_o(num), .vec_addr_o(vec),
        .sp_addr_o(sp), .core_ack_i(ack), .core_ret_i(ret));
    evpa_core_model core (.clk_i(clk_i), .rstn_i(rstn_i),
        .take_req_i(take), .en_i(en), .lat_i(lat), .ack_o(ack));
    initial forever #50 clk_i = ~clk_i;
    initial foreach (tbl[i]) tbl[i] = {18'h0_0100, i[5:0], 8'h01};
    function logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task wrap_up();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
             input logic [3:0] p);
        @(posedge clk_i);
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h00_0000, ad};
        hwrite <= w;
        hprot <= p;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        r = hrdata;
    endtask : bus
    task wr(input logic [7:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d, 4'h2);
    endtask : wr
    task rdc(input logic [7:0] ad, input logic [31:0] e);
        bus(1'b0, ad, 32'h0, 4'h2);
        chk(r, e);
        chk({31'h0, hresp}, 32'h0);
    endtask : rdc
    task setp(input int e, input logic [2:0] p);
        int w;
        pr[e] = p;
        w = e & ~3;
        wr(8'(64 + w), {5'h00, pr[w+3], 5'h00, pr[w+2], 5'h00, pr[w+1],
            5'h00, pr[w]});
        rdc(8'(64 + w), {5'h00, pr[w+3], 5'h00, pr[w+2], 5'h00, pr[w+1],
            5'h00, pr[w]});
    endtask : setp
    task pulse(input logic [29:0] l, input logic [15:0] s);
        @(posedge clk_i);
        irq <= l;
        sysr <= s;
        repeat (2) @(posedge clk_i);
        irq <= 30'h0;
        sysr <= 16'h0;
    endtask : pulse
    task waitt(input logic [5:0] e);
        do @(negedge clk_i); while (take !== 1'b1);
        chk(num, e);
        chk(vec, 32'h0000_0100 + {e, 2'b00});
        chk({31'h0, tbl[vec[7:2]][0]}, 32'h1);
    endtask : waitt
    task act(input logic [29:0] l, input logic [15:0] s, input logic [5:0] e);
        @(posedge clk_i);
        en <= 1'b1;
        pulse(l, s);
        waitt(e);
        do @(posedge clk_i); while (take !== 1'b0);
        en <= 1'b0;
    endtask : act
    task quiet();
        repeat (4) @(negedge clk_i);
        chk(take, 1'b0);
    endtask : quiet
    task drain();
        @(posedge clk_i);
        en <= 1'b1;
        lat <= rnd[1:0];
        repeat (12) begin
            repeat (3) @(posedge clk_i);
            ret <= 1'b1;
            @(posedge clk_i);
            ret <= 1'b0;
        end
        en <= 1'b0;
        rdc(OFF_ACT_L, 32'h0);
        rdc(OFF_ACT_H, 32'h0);
        rdc(OFF_PEND_L, 32'h0);
    endtask : drain
    initial begin
        repeat (30000) @(posedge clk_i);
        errors++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        do @(negedge clk_i); while (take !== 1'b1);
        chk(num, EXC_RESET);
        chk(vec, 32'h0000_0004);
        chk(sp, TBR_RESET);
        rdc(OFF_SPLIT, 32'h0);
        rdc(8'h50, 32'h0);
        wr(8'h40, 32'hFFFF_FFFF);
        rdc(8'h40, 32'h0);
        wr(8'h30, 32'hFFFF_FFFF);
        rdc(8'h30, 32'h0);
        wr(8'h50, 32'hFFFF_FFFF);
        rdc(8'h50, 32'h0707_0707);
        wr(8'h50, 32'h0);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, OFF_TBR, bd[i], (i == 0) ? 4'h0 : 4'h2);
            rdc(OFF_TBR, be[i]);
        end
        chk(sp, 32'h0000_0100);
        en <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            a = rnd % 30;
            rnd = lfsr(rnd);
            b = rnd % 30;
            if (b == a) b = (a + 1) % 30;
            pulse((30'h1 << a) | (30'h1 << b), 16'h0);
            waitt(6'(16 + ((a < b) ? a : b)));
            drain();
        end
        setp(16 + a, 3'h5);
        setp(16 + b, 3'h3);
        pulse((30'h1 << a) | (30'h1 << b), 16'h0);
        waitt(6'(16 + b));
        drain();
        setp(16 + a, 3'h0);
        setp(16 + b, 3'h0);
        setp(19, 3'h4);
        setp(17, 3'h4);
        setp(21, 3'h2);
        act(30'h8, 16'h0, 6'd19);
        pulse(30'h2, 16'h0);
        quiet();
        rdc(OFF_PEND_L, 32'h0002_0000);
        rdc(OFF_ACT_L, 32'h0008_0000);
        rdc(OFF_STATUS, 32'h0000_5153);
        pulse(30'h20, 16'h0);
        waitt(6'd21);
        drain();
        wr(OFF_SPLIT, 32'h1);
        rdc(OFF_SPLIT, 32'h1);
        setp(17, 3'h5);
        setp(25, 3'h3);
        act(30'h8, 16'h0, 6'd19);
        pulse(30'h2, 16'h0);
        quiet();
        pulse(30'h200, 16'h0);
        waitt(6'd25);
        drain();
        setp(18, 3'h5);
        setp(22, 3'h4);
        pulse(30'h44, 16'h0);
        waitt(6'd22);
        drain();
        wr(OFF_SPLIT, 32'h0);
        pulse(30'h1, 16'h0008);
        waitt(EXC_HARD);
        drain();
        act(30'h0, 16'h0008, EXC_HARD);
        pulse(30'h0, 16'h0004);
        waitt(EXC_NMI);
        drain();
        wr(OFF_SWPEND, 32'h0000_000E);
        waitt(6'd14);
        drain();
        wrap_up();
    end
endmodule : exception_vector_priority_arbiter_bench
